//--- shared/gpt_pkg.sv
// Package of constants for the general purpose timer set
package gpt_pkg;

    // Structure
    localparam int NUM_TIMERS = 5;
    localparam int ADR_W      = 8;
    localparam int DAT_W      = 32;

    // Register index inside one timer's block; the timer number is adr[6:4]
    localparam logic [1:0] REG_CONTROL = 2'h0;
    localparam logic [1:0] REG_COUNT   = 2'h1;
    localparam logic [1:0] REG_PERIOD  = 2'h2;
    localparam logic [1:0] REG_IRQ     = 2'h3;
    localparam logic [2:0] TIMER_LAST  = 3'h4;

    // Control field positions
    localparam int RUN_BIT   = 15;
    localparam int IDLE_BIT  = 13;
    localparam int GATE_BIT  = 6;
    localparam int PS_HI     = 5;
    localparam int PS_LO     = 4;
    localparam int PAIR_BIT  = 3;
    localparam int SYNC_BIT  = 2;
    localparam int SRC_BIT   = 1;

    // Interrupt control field positions
    localparam int IRQ_FLAG_BIT = 0;
    localparam int IRQ_EN_BIT   = 1;
    localparam int IRQ_PRIO_LO  = 2;
    localparam int IRQ_PRIO_HI  = 4;

    // Writable bits; everything else reads as zero
    localparam logic [15:0] CTL_MASK_PRIMARY = 16'ha076;
    localparam logic [15:0] CTL_MASK_LOW     = 16'ha07a;
    localparam logic [15:0] CTL_MASK_HIGH    = 16'ha072;
    localparam logic [15:0] IRQ_MASK         = 16'h001f;

    // Reset values
    localparam logic [15:0] CTL_RESET    = 16'h0000;
    localparam logic [15:0] COUNT_RESET  = 16'h0000;
    localparam logic [15:0] PERIOD_RESET = 16'hffff;
    localparam logic [15:0] IRQ_RESET    = 16'h0000;

    // Prescaler terminal counts for codes 00, 01, 10, 11
    localparam logic [7:0] PS_DIV1_LAST   = 8'h00;
    localparam logic [7:0] PS_DIV8_LAST   = 8'h07;
    localparam logic [7:0] PS_DIV64_LAST  = 8'h3f;
    localparam logic [7:0] PS_DIV256_LAST = 8'hff;

endpackage

//--- hdl/gpt_timer_set.sv
// General purpose timer set: one primary timer and two pairable secondary pairs
//
// Behaviour
// - Primary timer is a 16-bit counter for time base or interval counting.
// - Source bit one counts external pin rising edges; zero counts instruction clock.
// - Primary mode decoded from source, gate and sync bits into four modes.
// - Run bit 15 starts the primary timer; clearing it stops it.
// - Idle-stop bit 13 halts the timer in Idle mode; clear keeps running.
// - Gate enable bit 6 acts only with internal source, ignored otherwise.
// - Prescale field divides input by 1, 8, 64 or 256.
// - Sync bit 2 chooses external synchronization; ignored with internal source.
// - Primary external synchronizer sits after the prescaler.
// - Primary timer can run from the slow crystal, also asynchronously.
// - Unimplemented primary control bits read as zero.
// - Low-word secondary timers always synchronize after their prescaler.
// - High-word secondary timers always synchronize before their prescaler.
// - Secondary timers offer timer, gated and synchronous counter modes only.
// - A low-word secondary timer drives an ADC conversion trigger.
// - Pair select bit 3 of low timer joins two timers into 32 bits.
// - In pair mode only low control governs, except high idle-stop bit.
// - In pair mode interrupts use the high timer's flag, enable, priority.
// - Only timers two/three and four/five pair; lower number is low word.
// - Pair period is high period register over low period register.
`timescale 1ns/1ps
`default_nettype none

module gpt_timer_set (
    // Clock and reset
    input  wire logic        ref_clk,
    input  wire logic        rst,
    // Wishbone slave
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    // Device state and pins
    input  wire logic        idle_mode,
    input  wire logic        primary_ext_clock_pin,
    input  wire logic [3:0]  secondary_ext_clock_pin,
    // Interrupt requests and ADC trigger
    output logic      [4:0]  irq_req_q,
    output logic      [14:0] irq_prio_q,
    output logic             adc_trigger_q
);

    localparam int N = gpt_pkg::NUM_TIMERS;

    logic [15:0] ctl_q  [N];
    logic [15:0] tmr_q  [N];
    logic [15:0] tmr_d  [N];
    logic [15:0] pr_q   [N];
    logic [15:0] irq_q  [N];
    logic [N-1:0] run;
    logic [N-1:0] tick;
    logic [N-1:0] gate_fall;
    logic [N-1:0] set_flag;
    logic [N-1:0] match_ev;
    logic [N-1:0] pair_low;
    logic [N-1:0] ext_pin;
    logic         acc;
    logic         wr;
    logic         valid;
    logic [2:0]   tsel;
    logic [1:0]   rsel;

    // Byte-lane merge of a 16-bit register, shared by every writable register
    function automatic logic [15:0] merge16(input logic [15:0] old,
                                            input logic [31:0] dat,
                                            input logic [3:0]  sel);
        logic [15:0] r;
        r = old;
        if (sel[0]) begin
            r[7:0] = dat[7:0];
        end
        if (sel[1]) begin
            r[15:8] = dat[15:8];
        end
        return r;
    endfunction

    function automatic logic [7:0] presc_last(input logic [1:0] code);
        logic [7:0] r;
        r = gpt_pkg::PS_DIV1_LAST;
        unique case (code)
            2'h0: r = gpt_pkg::PS_DIV1_LAST;
            2'h1: r = gpt_pkg::PS_DIV8_LAST;
            2'h2: r = gpt_pkg::PS_DIV64_LAST;
            2'h3: r = gpt_pkg::PS_DIV256_LAST;
        endcase
        return r;
    endfunction

    function automatic logic [15:0] ctl_mask(input int idx);
        logic [15:0] r;
        if (idx == 0) begin
            r = gpt_pkg::CTL_MASK_PRIMARY;
        end else if (idx == 1 || idx == 3) begin
            r = gpt_pkg::CTL_MASK_LOW;
        end else begin
            r = gpt_pkg::CTL_MASK_HIGH;
        end
        return r;
    endfunction

    // Register select of one timer, decoded alike for all four register files
    function automatic logic reg_hit(input logic       strobe,
                                     input logic [2:0] tmr,
                                     input logic [1:0] rg,
                                     input int         idx,
                                     input logic [1:0] want);
        return strobe && tmr == 3'(idx) && rg == want;
    endfunction

    assign ext_pin = {secondary_ext_clock_pin, primary_ext_clock_pin};
    // Ack high masks the second cycle, so a held strobe is not taken twice
    assign acc     = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    assign wr      = acc & wb_we_i;
    assign tsel    = wb_adr_i[6:4];
    assign rsel    = wb_adr_i[3:2];
    assign valid   = ~wb_adr_i[7] & (tsel <= gpt_pkg::TIMER_LAST);

    // Only 2/3 and 4/5 pair, steered by the low timer's pair bit
    assign pair_low = {1'b0, ctl_q[3][gpt_pkg::PAIR_BIT], 1'b0,
                       ctl_q[1][gpt_pkg::PAIR_BIT], 1'b0};

    // Run qualification; a paired high word's idle-stop still halts the pair
    always_comb begin
        for (int i = 0; i < N; i++) begin
            run[i] = ctl_q[i][gpt_pkg::RUN_BIT]
                     & ~(idle_mode & ctl_q[i][gpt_pkg::IDLE_BIT]);
        end
        // Indexing by the low word keeps the lookup of the high word's bits in range
        for (int lo = 1; lo < N; lo += 2) begin
            if (pair_low[lo]) begin
                run[lo] = run[lo] & ~(idle_mode & ctl_q[lo+1][gpt_pkg::IDLE_BIT]);
            end
        end
    end

    // Input path of each timer: source select, gating, prescaler, synchronizer
    for (genvar g = 0; g < N; g++) begin : g_path
        localparam bit SYNC_BEFORE = (g == 2) || (g == 4);
        logic       s1_q;
        logic       s2_q;
        logic       s3_q;
        logic       raw_q;
        logic       ps1_q;
        logic       ps2_q;
        logic [7:0] pcnt_q;
        logic       src;
        logic       prev;
        logic       ext;
        logic       gated;
        logic       evt;
        logic       po;
        logic       late_sync;
        logic [7:0] lim;

        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                s1_q  <= 1'b0;
                s2_q  <= 1'b0;
                s3_q  <= 1'b0;
                raw_q <= 1'b0;
            end else begin
                s1_q  <= ext_pin[g];
                s2_q  <= s1_q;
                s3_q  <= s2_q;
                raw_q <= ext_pin[g];
            end
        end

        // High-word timers sample the pin through two flops before the prescaler
        assign src   = SYNC_BEFORE ? s2_q : ext_pin[g];
        assign prev  = SYNC_BEFORE ? s3_q : raw_q;
        assign ext   = ctl_q[g][gpt_pkg::SRC_BIT];
        // Gate bit only matters with the internal source
        assign gated = ~ext & ctl_q[g][gpt_pkg::GATE_BIT];
        // Rising edges of the pin, or instruction clocks qualified by the gate
        assign evt   = ext ? (src & ~prev) : (~gated | src);
        assign lim   = presc_last(ctl_q[g][gpt_pkg::PS_HI:gpt_pkg::PS_LO]);
        assign po    = run[g] & evt & (pcnt_q == lim);

        // Cleared while stopped, so a restart always gives a full first division
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                pcnt_q <= 8'h00;
            end else if (!run[g]) begin
                pcnt_q <= 8'h00;
            end else if (evt) begin
                pcnt_q <= (pcnt_q == lim) ? 8'h00 : pcnt_q + 8'h01;
            end
        end

        // Post-prescaler synchronizer; costs two cycles of latency per tick
        always_ff @(posedge ref_clk or posedge rst) begin
            if (rst) begin
                ps1_q <= 1'b0;
                ps2_q <= 1'b0;
            end else begin
                ps1_q <= po;
                ps2_q <= ps1_q;
            end
        end

        // Primary: sync bit chooses; low words always late; high words already early
        if (g == 0) begin : g_pri
            assign late_sync = ext & ctl_q[g][gpt_pkg::SYNC_BIT];
        end else begin : g_sec
            assign late_sync = ext & !SYNC_BEFORE;
        end

        // Async mode takes the prescaled pin edge directly, e.g. the slow crystal
        assign tick[g]      = late_sync ? ps2_q : po;
        assign gate_fall[g] = run[g] & gated & prev & ~src;
    end

    // Next count, period match and flag events
    always_comb begin
        for (int i = 0; i < N; i++) begin
            tmr_d[i]    = tmr_q[i];
            set_flag[i] = 1'b0;
            match_ev[i] = 1'b0;
            if (run[i] & tick[i]) begin
                if (tmr_q[i] == pr_q[i]) begin
                    tmr_d[i]    = 16'h0000;
                    set_flag[i] = 1'b1;
                    match_ev[i] = 1'b1;
                end else begin
                    tmr_d[i] = tmr_q[i] + 16'h0001;
                end
            end
            if (gate_fall[i]) begin
                set_flag[i] = 1'b1;
            end
        end
        for (int lo = 1; lo < N; lo += 2) begin
            if (pair_low[lo]) begin
                tmr_d[lo]      = tmr_q[lo];
                tmr_d[lo+1]    = tmr_q[lo+1];
                // The low word's own 16-bit match must not trigger the converter
                match_ev[lo]   = 1'b0;
                set_flag[lo]   = 1'b0;
                set_flag[lo+1] = gate_fall[lo];
                match_ev[lo+1] = 1'b0;
                if (run[lo] & tick[lo]) begin
                    if ({tmr_q[lo+1], tmr_q[lo]} == {pr_q[lo+1], pr_q[lo]}) begin
                        tmr_d[lo]      = 16'h0000;
                        tmr_d[lo+1]    = 16'h0000;
                        set_flag[lo+1] = 1'b1;
                        match_ev[lo]   = 1'b1;
                    end else begin
                        {tmr_d[lo+1], tmr_d[lo]} = {tmr_q[lo+1], tmr_q[lo]} + 32'h1;
                    end
                end
            end
        end
    end

    // Control registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                ctl_q[i] <= gpt_pkg::CTL_RESET;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (reg_hit(wr & valid, tsel, rsel, i, gpt_pkg::REG_CONTROL)) begin
                    ctl_q[i] <= merge16(ctl_q[i], wb_dat_i, wb_sel_i) & ctl_mask(i);
                end
            end
        end
    end

    // Counters; a software write wins over counting in the same cycle
    // A write to one half of a pair lands in that half only; the carry resumes next tick
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                tmr_q[i] <= gpt_pkg::COUNT_RESET;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (reg_hit(wr & valid, tsel, rsel, i, gpt_pkg::REG_COUNT)) begin
                    tmr_q[i] <= merge16(tmr_q[i], wb_dat_i, wb_sel_i);
                end else begin
                    tmr_q[i] <= tmr_d[i];
                end
            end
        end
    end

    // Period registers
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                pr_q[i] <= gpt_pkg::PERIOD_RESET;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (reg_hit(wr & valid, tsel, rsel, i, gpt_pkg::REG_PERIOD)) begin
                    pr_q[i] <= merge16(pr_q[i], wb_dat_i, wb_sel_i);
                end
            end
        end
    end

    // Interrupt control: flag is write-one-to-clear, and a new event beats the clear
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            for (int i = 0; i < N; i++) begin
                irq_q[i] <= gpt_pkg::IRQ_RESET;
            end
        end else begin
            for (int i = 0; i < N; i++) begin
                if (reg_hit(wr & valid, tsel, rsel, i, gpt_pkg::REG_IRQ)) begin
                    irq_q[i] <= merge16(irq_q[i], wb_dat_i, wb_sel_i) & gpt_pkg::IRQ_MASK;
                    irq_q[i][gpt_pkg::IRQ_FLAG_BIT] <= set_flag[i]
                        | (irq_q[i][gpt_pkg::IRQ_FLAG_BIT]
                           & ~(wb_sel_i[0] & wb_dat_i[gpt_pkg::IRQ_FLAG_BIT]));
                end else if (set_flag[i]) begin
                    irq_q[i][gpt_pkg::IRQ_FLAG_BIT] <= 1'b1;
                end
            end
        end
    end

    // Request and trigger outputs; a paired low word never requests
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            irq_req_q     <= 5'h00;
            irq_prio_q    <= 15'h0000;
            adc_trigger_q <= 1'b0;
        end else begin
            for (int i = 0; i < N; i++) begin
                irq_req_q[i] <= irq_q[i][gpt_pkg::IRQ_FLAG_BIT]
                                & irq_q[i][gpt_pkg::IRQ_EN_BIT] & ~pair_low[i];
                irq_prio_q[3*i +: 3] <= irq_q[i][gpt_pkg::IRQ_PRIO_HI:gpt_pkg::IRQ_PRIO_LO];
            end
            // Only the first low word is wired to the converter
            adc_trigger_q <= match_ev[1];
        end
    end

    // Bus answer: one wait state, unmapped addresses read zero and ignore writes
    // Data is zero outside a valid read, so several slaves can share an OR bus
    always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h00000000;
        end else begin
            wb_ack_o <= acc;
            wb_dat_o <= 32'h00000000;
            if (acc && !wb_we_i && valid) begin
                unique case (rsel)
                    gpt_pkg::REG_CONTROL: wb_dat_o <= {16'h0000, ctl_q[tsel]};
                    gpt_pkg::REG_COUNT:   wb_dat_o <= {16'h0000, tmr_q[tsel]};
                    gpt_pkg::REG_PERIOD:  wb_dat_o <= {16'h0000, pr_q[tsel]};
                    gpt_pkg::REG_IRQ:     wb_dat_o <= {16'h0000, irq_q[tsel]};
                endcase
            end
        end
    end

endmodule

`default_nettype wire

//--- verification/gpt_timer_set_monitor.sv
// Checker for bus answers and outputs of the timer set
`timescale 1ns/1ps
`default_nettype none

module gpt_monitor (
    // Clock and reset
    input wire logic        ref_clk,
    input wire logic        rst,
    // Bus
    input wire logic        wb_cyc_i,
    input wire logic        wb_stb_i,
    input wire logic        wb_we_i,
    input wire logic [7:0]  wb_adr_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic        wb_ack_o,
    // Outputs
    input wire logic [14:0] irq_prio_q,
    input wire logic        adc_trigger_q
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);

    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_rd_unmapped;
        s_req ##0 (!wb_we_i && wb_adr_i[7]);
    endsequence
    sequence s_rd_primary_ctl;
        s_req ##0 (!wb_we_i && wb_adr_i == 8'h00);
    endsequence

    AST_ACK_ANSWER: assert property (s_req |=> wb_ack_o ##1 !wb_ack_o)
        else $error("ack not one cycle after request");
    AST_ACK_CAUSE: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i && wb_stb_i))
        else $error("ack without request");
    AST_ACK_SINGLE: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack longer than one cycle");
    AST_DAT_IDLE: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data outside ack");
    AST_DAT_UPPER: assert property (wb_ack_o |-> wb_dat_o[31:16] == 16'h0)
        else $error("upper read data not zero");
    AST_UNMAPPED: assert property (s_rd_unmapped |=> wb_dat_o == 32'h0)
        else $error("unmapped read not zero");
    AST_CTL_ZERO: assert property (
        s_rd_primary_ctl |=> (wb_dat_o[15:0] & ~gpt_pkg::CTL_MASK_PRIMARY) == 16'h0)
        else $error("unimplemented control bits not zero");
    AST_ADC_PULSE: assert property (adc_trigger_q |=> !adc_trigger_q)
        else $error("conversion trigger not a pulse");
    AST_PRIO_WRITE: assert property (
        $changed(irq_prio_q) |-> $past(wb_cyc_i && wb_we_i))
        else $error("priority changed without a write");
endmodule

bind gpt_timer_set gpt_monitor u_mon (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i,
    .wb_adr_i, .wb_dat_o, .wb_ack_o, .irq_prio_q, .adc_trigger_q);

`default_nettype wire

//--- verification/tb.sv
// Self-checking testbench for the timer set
`timescale 1ns/1ps
`default_nettype none

module tb;
    logic        ref_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic        idle_mode, adc_trigger_q, adc_seen;
    logic [7:0]  wb_adr_i;
    logic [3:0]  wb_sel_i;
    logic [31:0] wb_dat_i, wb_dat_o;
    logic [4:0]  pins, irq_req_q;
    logic [14:0] irq_prio_q;
    logic [15:0] rd, mask;
    logic [2:0]  pr;
    int          failures, compares, seed, t, r, n, p, m;
    int          div [4] = '{1, 8, 64, 256};

    gpt_timer_set DUT (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
        .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .idle_mode,
        .primary_ext_clock_pin(pins[0]), .secondary_ext_clock_pin(pins[4:1]),
        .irq_req_q, .irq_prio_q, .adc_trigger_q);

    initial begin
        ref_clk = 1'b0;
        forever #4 ref_clk = ~ref_clk;
    end

    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic in_range(input logic [15:0] got, input int lo, input int hi);
        check({15'h0, got >= 16'(lo) && got <= 16'(hi)}, 16'h1);
    endtask

    task automatic give_verdict;
        $display("compares %0d failures %0d", compares, failures);
        if (failures == 0 && compares > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask

    // Classic cycle; waits for ack however long it takes, up to a cut-off
    task automatic bus(input logic w, input int tm, input int rg, input logic [15:0] d);
        int k;
        @(posedge ref_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i  <= w;
        wb_adr_i <= 8'(tm * 16 + rg * 4);
        wb_dat_i <= {16'h0, d};
        k = 0;
        do begin
            @(posedge ref_clk);
            k++;
        end while (wb_ack_o !== 1'b1 && k < 50);
        if (k >= 50)
            failures++;
        rd = wb_dat_o[15:0];
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask

    task automatic wait_irq(input int bit_no);
        n = 0;
        while (irq_req_q[bit_no] !== 1'b1 && n < 100) begin
            @(posedge ref_clk);
            n++;
            adc_seen = adc_seen | adc_trigger_q;
        end
    endtask

    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        give_verdict();
    end

    initial begin
        seed = 32'h4b86c81b;
        rst = 1'b1;
        {wb_cyc_i, wb_stb_i, wb_we_i, idle_mode} = 4'h0;
        wb_adr_i = 8'h0;
        wb_sel_i = 4'h3;
        wb_dat_i = 32'h0;
        pins = 5'h0;
        repeat (20) @(posedge ref_clk);
        rst <= 1'b0;
        // Reset values, writable bits; a sixth timer and 8'h80 are unmapped
        for (t = 0; t < 6; t++) begin
            mask = t == 0 ? gpt_pkg::CTL_MASK_PRIMARY : t == 5 ? 16'h0 :
                   t % 2 == 1 ? gpt_pkg::CTL_MASK_LOW : gpt_pkg::CTL_MASK_HIGH;
            for (r = 0; r < 4; r++) begin
                bus(1'b0, t, r, 16'h0);
                check(rd, (r == 2 && t < 5) ? gpt_pkg::PERIOD_RESET : 16'h0);
            end
            bus(1'b1, t, 0, 16'h7fff);
            bus(1'b0, t, 0, 16'h0);
            check(rd, 16'h7fff & mask);
            bus(1'b1, t, 0, 16'h0);
        end
        bus(1'b0, 8, 0, 16'h0);
        check(rd, 16'h0);
        // Prescaler codes; counter stopped by the run bit
        for (r = 0; r < 4; r++) begin
            bus(1'b1, 0, 1, 16'h0);
            bus(1'b1, 0, 0, 16'h8000 | 16'(r << 4));
            repeat (512) @(posedge ref_clk);
            bus(1'b1, 0, 0, 16'h0);
            bus(1'b0, 0, 1, 16'h0);
            in_range(rd, 514 / div[r] - 2, 514 / div[r] + 2);
        end
        // Idle stop
        idle_mode <= 1'b1;
        bus(1'b1, 0, 1, 16'h0);
        bus(1'b1, 0, 0, 16'ha000);
        repeat (100) @(posedge ref_clk);
        bus(1'b0, 0, 1, 16'h0);
        check(rd, 16'h0);
        bus(1'b1, 0, 1, 16'h0);
        bus(1'b1, 0, 0, 16'h8000);
        repeat (100) @(posedge ref_clk);
        bus(1'b1, 0, 0, 16'h0);
        bus(1'b0, 0, 1, 16'h0);
        in_range(rd, 99, 105);
        idle_mode <= 1'b0;
        // Period match, interrupt enable, priority and flag clear on each timer
        for (t = 0; t < 5; t++) begin
            p = 3 + $unsigned($random(seed)) % 28;
            pr = 3'($random(seed));
            bus(1'b1, t, 2, 16'(p));
            bus(1'b1, t, 1, 16'h0);
            bus(1'b1, t, 3, {11'h0, pr, 2'b10});
            adc_seen = 1'b0;
            bus(1'b1, t, 0, 16'h8000);
            wait_irq(t);
            in_range(16'(n), p - 2, p + 4);
            repeat (2) begin
                @(posedge ref_clk);
                adc_seen = adc_seen | adc_trigger_q;
            end
            check({15'h0, adc_seen}, {15'h0, t == 1});
            check({13'h0, irq_prio_q[3 * t +: 3]}, {13'h0, pr});
            bus(1'b1, t, 0, 16'h0);
            bus(1'b1, t, 3, {11'h0, pr, 2'b11});
            bus(1'b1, t, 2, 16'hffff);
            bus(1'b0, t, 3, 16'h0);
            check(rd, {11'h0, pr, 2'b10});
            check({11'h0, irq_req_q}, 16'h0);
        end
        // External edges: primary async, primary sync, then each secondary
        for (r = 0; r < 6; r++) begin
            t = r < 2 ? 0 : r - 1;
            m = 5 + $unsigned($random(seed)) % 16;
            bus(1'b1, t, 1, 16'h0);
            bus(1'b1, t, 0, 16'h8042 | 16'(r == 1) << 2);
            repeat (m) begin
                pins[t] <= 1'b1;
                repeat (3) @(posedge ref_clk);
                pins[t] <= 1'b0;
                repeat (3) @(posedge ref_clk);
            end
            repeat (6) @(posedge ref_clk);
            bus(1'b1, t, 0, 16'h0);
            bus(1'b0, t, 1, 16'h0);
            check(rd, 16'(m));
        end
        // Gated accumulation on the fourth timer; enable and priority cleared first
        bus(1'b1, 3, 3, 16'h0);
        bus(1'b1, 3, 1, 16'h0);
        bus(1'b1, 3, 0, 16'h8040);
        pins[3] <= 1'b1;
        repeat (40) @(posedge ref_clk);
        pins[3] <= 1'b0;
        repeat (6) @(posedge ref_clk);
        bus(1'b1, 3, 0, 16'h0);
        bus(1'b0, 3, 1, 16'h0);
        in_range(rd, 38, 43);
        bus(1'b0, 3, 3, 16'h0);
        check(rd, 16'h1);
        bus(1'b1, 3, 3, 16'h1);
        // Pair; upper prescale set but ignored, so 20 ticks to the match
        bus(1'b1, 2, 0, 16'h0030);
        bus(1'b1, 2, 2, 16'h0001);
        bus(1'b1, 1, 2, 16'h0004);
        bus(1'b1, 2, 1, 16'h0);
        bus(1'b1, 1, 1, 16'hfff0);
        bus(1'b1, 2, 3, 16'h0002);
        bus(1'b1, 1, 3, 16'h0002);
        bus(1'b1, 1, 0, 16'h8008);
        wait_irq(2);
        in_range(16'(n), 18, 25);
        check({15'h0, irq_req_q[1]}, 16'h0);
        bus(1'b1, 1, 0, 16'h0);
        bus(1'b0, 1, 3, 16'h0);
        check(rd, 16'h2);
        give_verdict();
    end
endmodule

`default_nettype wire
